// file: rtl/led_fade_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the LED fade block
// Assumes: 10 MHz core clock
// Notes: Definitions only
`ifndef LED_FADE_DEFS_SVH
`define LED_FADE_DEFS_SVH

// Register byte offsets on the configuration port
`define LOW_CFG_OUT0_OFS 8'h07
`define LOW_CFG_OUT1_3_OFS 8'h09
`define LOW_CFG_OUT4_6_OFS 8'h0b
`define LOW_CFG_OUT7_9_OFS 8'h0d
`define LOW_CFG_RESET 8'h00

// Field positions
`define RAMP_DOWN_SEL_HI 7
`define RAMP_DOWN_SEL_LO 6
`define LOW_BRIGHT_HI 5
`define LOW_BRIGHT_LO 3
`define REPEAT_BIT 2
`define HIGH_HOLD_BIT 1
`define LOW_HOLD_BIT 0

// Timing: one period step is 20 ms, split into 100 one-percent ticks
`define CLK_KHZ 10000
`define FADE_STEP_MS 20
`define FADE_STEP_CYCLES (`FADE_STEP_MS * `CLK_KHZ)
`define PCT_STEPS 100
`define PCT_TICK_CYCLES (`FADE_STEP_CYCLES / `PCT_STEPS)

`endif

// file: rtl/led_fade_pkg.sv
// Purpose: Types shared by the LED fade files
// Assumes: Nothing beyond the defs header
// Notes: Percent levels run 0..100
package led_fade_pkg;

    typedef logic [6:0] pct_t;
    typedef logic [7:0] period_t;

    // Low-phase configuration register layout
    typedef struct packed {
        logic [1:0] ramp_down_period_sel;
        logic [2:0] low_bright;
        logic repeat_touch;
        logic high_hold_period_sel;
        logic low_hold_period_sel;
    } low_phase_cfg_s;

    // High-phase settings arriving from the ramp-up configuration logic
    typedef struct packed {
        logic [1:0] ramp_up_period_sel;
        logic [2:0] high_bright;
    } high_phase_cfg_s;

    // Sequencer states, Gray along the effect path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_UP = 3'h1,
        ST_HIGH = 3'h3,
        ST_DOWN = 3'h2,
        ST_LOW = 3'h6,
        ST_DONE = 3'h7
    } fade_state_e;

endpackage

// file: rtl/fade_sequencer.sv
// Purpose: One group's fade sequence producing a brightness level in percent
// Assumes: pct_tick_i pulses once every hundredth of a 20 ms step
// Notes: Ramps move one percent every period-value ticks
`timescale 1ns/1ps
`include "led_fade_defs.svh"
module fade_sequencer
    import led_fade_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic pct_tick_i,
    input wire low_phase_cfg_s low_cfg_i,
    input wire high_phase_cfg_s high_cfg_i,
    input wire period_t [3:0] global_fade_period_i,
    input wire logic touch_i,
    output pct_t level_o
);

    fade_state_e state_q, state_d; // Effect phase
    pct_t level_q, level_d; // Present brightness
    logic [15:0] cnt_q, cnt_d; // Tick counter within a ramp step or hold
    logic touch_q, touch_d; // Last touch, for edge detection
    period_t cur_period; // Period value of the present phase
    pct_t target; // Level the present ramp heads to
    pct_t high_pct, low_pct;
    logic [15:0] limit; // Ticks this step or hold lasts

    // Low target code to percent
    always_comb
    begin
        unique case (low_cfg_i.low_bright)
            3'h0: low_pct = 7'h00;
            3'h1: low_pct = 7'h0a;
            3'h2: low_pct = 7'h14;
            3'h3: low_pct = 7'h1e;
            3'h4: low_pct = 7'h28;
            3'h5: low_pct = 7'h3c;
            3'h6: low_pct = 7'h50;
            3'h7: low_pct = 7'h64;
        endcase
    end

    // High target code to percent
    always_comb
    begin
        unique case (high_cfg_i.high_bright)
            3'h0: high_pct = 7'h64;
            3'h1: high_pct = 7'h5a;
            3'h2: high_pct = 7'h50;
            3'h3: high_pct = 7'h41;
            3'h4: high_pct = 7'h32;
            3'h5: high_pct = 7'h28;
            3'h6: high_pct = 7'h14;
            3'h7: high_pct = 7'h00;
        endcase
    end

    // Period of the present phase, and how long a step or hold lasts
    always_comb
    begin
        cur_period = 8'h00;
        target = 7'h00;
        unique case (state_q)
            ST_UP:
            begin
                cur_period = global_fade_period_i[high_cfg_i.ramp_up_period_sel];
                target = high_pct;
            end
            ST_HIGH: cur_period = global_fade_period_i[{1'b0, low_cfg_i.high_hold_period_sel}];
            ST_DOWN:
            begin
                cur_period = global_fade_period_i[low_cfg_i.ramp_down_period_sel];
                target = low_pct;
            end
            ST_LOW: cur_period = global_fade_period_i[{1'b0, low_cfg_i.low_hold_period_sel}];
            default: cur_period = 8'h00;
        endcase
        // Holds last period * 20 ms; ramp steps last period ticks per percent
        if (state_q == ST_HIGH || state_q == ST_LOW)
            limit = 16'(cur_period) * 16'(`PCT_STEPS);
        else
            limit = {8'h00, cur_period};
    end

    // Next state of the sequencer
    always_comb
    begin
        state_d = state_q;
        level_d = level_q;
        cnt_d = cnt_q;
        touch_d = touch_i;
        unique case (state_q)
            ST_IDLE:
            begin
                level_d = 7'h00;
                cnt_d = 16'h0000;
                if (touch_i && !touch_q)
                    state_d = ST_UP;
            end
            ST_UP, ST_DOWN:
            begin
                // Zero period jumps straight to the target
                if (level_q == target)
                begin
                    cnt_d = 16'h0000;
                    state_d = (state_q == ST_UP) ? ST_HIGH : ST_LOW;
                end
                else if (cur_period == 8'h00)
                    level_d = target;
                else if (pct_tick_i)
                begin
                    if (cnt_q + 16'h0001 >= limit)
                    begin
                        cnt_d = 16'h0000;
                        level_d = (level_q < target) ? level_q + 7'h01 : level_q - 7'h01;
                    end
                    else
                        cnt_d = cnt_q + 16'h0001;
                end
            end
            ST_HIGH, ST_LOW:
            begin
                if (cnt_q >= limit)
                begin
                    cnt_d = 16'h0000;
                    if (state_q == ST_HIGH)
                        state_d = ST_DOWN;
                    else if (low_cfg_i.repeat_touch && touch_i)
                        state_d = ST_UP;
                    else
                        state_d = ST_DONE;
                end
                else if (pct_tick_i)
                    cnt_d = cnt_q + 16'h0001;
            end
            ST_DONE:
            begin
                // Keep the low level until the button is let go
                if (!touch_i)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE; // Illegal codes recover to idle
        endcase
    end

    // Register the sequencer state
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            level_q <= 7'h00;
            cnt_q <= 16'h0000;
            touch_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            level_q <= level_d;
            cnt_q <= cnt_d;
            touch_q <= touch_d;
        end
    end

    assign level_o = level_q;

endmodule

// file: rtl/led_fade_low_phase_config.sv
// Purpose: Low-phase fade registers and PWM drive of ten active-low outputs
// Assumes: Touch and configuration inputs come from logic on core_clk_i
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`include "led_fade_defs.svh"

// Register map, one byte per output group:
//   07 serves output 0 only
//   09 serves outputs 1 to 3
//   0b serves outputs 4 to 6
//   0d serves outputs 7 to 9
// Each byte holds the ramp-down period select, the low target code, the
// repeat-while-touched bit, the high hold select and the low hold select.
// Any other address reads as zero and ignores writes.
// Reset clears every byte, which selects the first period for ramp-down and both holds,
// a low target of zero and no repeat.
//
// Brightness is shown by a 100-phase PWM shared by all outputs. At 10 MHz
// each output repeats its pattern at 100 kHz, far above what an eye sees,
// and one shared counter is cheaper than one per group.
// The effect timing runs from a slow percent tick, so the sequencers
// need only narrow counters; the tick period is a parameter so that a
// bench can shorten every duration by the same factor.
module led_fade_low_phase_config
    import led_fade_pkg::*;
#(
    parameter int PCT_TICK_CYCLES = `PCT_TICK_CYCLES, // Clocks per one percent tick
    parameter int NUM_GROUPS = 4 // Output groups, one register each
)
(
    // Clock and synchronous reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Register port: one-cycle strobes, address decoded on the strobe edge
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Shared period values and ramp-up settings kept by neighbouring registers
    input wire period_t [3:0] global_fade_period_i,
    input wire high_phase_cfg_s [3:0] high_cfg_i,
    // Touch level per group and the LED drive, low to light
    input wire logic [3:0] group_touch_i,
    output logic [9:0] general_output_n_o
);

    // No synchroniser here: touch and configuration come from core_clk_i logic

    // Register state
    low_phase_cfg_s [NUM_GROUPS-1:0] cfg_q, cfg_d; // Low-phase registers per group
    logic [7:0] rdata_q, rdata_d; // Registered read answer

    // Timing state
    logic [15:0] div_q, div_d; // Percent tick divider
    logic tick_q, tick_d; // One-cycle percent tick
    logic [6:0] pwm_q, pwm_d; // PWM phase 0..99

    // Output state
    logic [9:0] out_n_q, out_n_d; // Active-low output drive
    pct_t [NUM_GROUPS-1:0] level; // Brightness per group, from the sequencers

    // Group that drives each output
    // Output 0 stands alone; the other nine fall into groups of three
    function automatic logic [1:0] group_of(input int idx);
        if (idx == 0)
        begin
            return 2'h0;
        end
        else
        begin
            return 2'((idx - 1) / 3 + 1);
        end
    endfunction

    // Register index for an address; a miss leaves the hit bit low
    // Bit 2 flags a hit and bits 1:0 name the group, so that one decode
    // serves both the write and the read path
    function automatic logic [2:0] decode(input logic [7:0] addr);
        unique case (addr)
            `LOW_CFG_OUT0_OFS: return 3'h4; // Output 0
            `LOW_CFG_OUT1_3_OFS: return 3'h5; // Outputs 1 to 3
            `LOW_CFG_OUT4_6_OFS: return 3'h6; // Outputs 4 to 6
            `LOW_CFG_OUT7_9_OFS: return 3'h7; // Outputs 7 to 9
            default: return 3'h0; // Unmapped
        endcase
    endfunction

    // Register writes and reads
    // A read and a write in one cycle return the old byte, since the
    // answer is taken from the registered copy and not from cfg_d
    always_comb
    begin
        logic [2:0] sel; // Hit flag and group index
        sel = decode(reg_addr_i);
        // Hold everything unless a strobe says otherwise
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        // A write to a mapped byte replaces all of its fields at once
        if (reg_wr_i && sel[2])
        begin
            cfg_d[sel[1:0]] = low_phase_cfg_s'(reg_wdata_i);
        end
        // A read refreshes the answer, which then stands until the next read
        if (reg_rd_i)
        begin
            if (sel[2])
            begin
                rdata_d = 8'(cfg_q[sel[1:0]]);
            end
            else
            begin
                // Unmapped addresses answer zero
                rdata_d = 8'h00;
            end
        end
    end

    // Percent tick divider and PWM phase counter
    // The tick is a one-cycle enable, not a second clock, so every
    // sequencer stays in the core clock domain
    // Limitation: the divider is 16 bits wide, so PCT_TICK_CYCLES must
    // stay at or below 65536
    always_comb
    begin
        tick_d = 1'b0;
        div_d = div_q + 16'h0001;
        if (div_q == 16'(PCT_TICK_CYCLES - 1))
        begin
            // Wrap and fire one tick
            div_d = 16'h0000;
            tick_d = 1'b1;
        end
        // The PWM phase walks 0..99 and wraps, one phase per clock
        if (pwm_q == 7'(`PCT_STEPS - 1))
        begin
            pwm_d = 7'h00;
        end
        else
        begin
            pwm_d = pwm_q + 7'h01;
        end
    end

    // Each output lights while the PWM phase is below its group's level
    // A level of 0 never lights and a level of 100 lights on every phase
    // The drive is registered, so the LEDs lag the level by one clock,
    // far too little for anyone to see
    always_comb
    begin
        for (int i = 0; i < 10; i++)
        begin
            out_n_d[i] = !(pwm_q < level[group_of(i)]);
        end
    end

    // Register the configuration bytes and the read answer
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cfg_q <= {NUM_GROUPS{`LOW_CFG_RESET}};
            rdata_q <= 8'h00;
        end
        else
        begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // Register the tick divider and the PWM phase
    // Both restart from zero after reset so every group starts in step
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
            pwm_q <= 7'h00;
        end
        else
        begin
            div_q <= div_d;
            tick_q <= tick_d;
            pwm_q <= pwm_d;
        end
    end

    // Register the LED drive
    // All LEDs stay dark while reset is held
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            out_n_q <= 10'h3ff;
        end
        else
        begin
            out_n_q <= out_n_d;
        end
    end

    // One sequencer per output group
    // All groups share the tick and the period values; only the low-phase
    // byte, the ramp-up settings and the touch level differ
    // Their levels are read only through the PWM compare above
    for (genvar g = 0; g < NUM_GROUPS; g++)
    begin : g_seq
        fade_sequencer u_seq (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .pct_tick_i(tick_q),
            .low_cfg_i(cfg_q[g]),
            .high_cfg_i(high_cfg_i[g]),
            .global_fade_period_i(global_fade_period_i),
            .touch_i(group_touch_i[g]),
            .level_o(level[g])
        );
    end

    // Both outputs come straight from flip-flops
    assign reg_rdata_o = rdata_q;
    assign general_output_n_o = out_n_q;

endmodule

// file: tb/fade_cfg_props.sv
// Purpose: Port checker for the low-phase fade block
// Assumes: Registers at 07, 09, 0b and 0d
// Notes: A shadow copy tracks written bytes
`timescale 1ns/1ps
module fade_cfg_props
    import led_fade_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [3:0] group_touch_i,
    input wire logic [9:0] general_output_n_o
);
    logic [7:0] shadow_q [4];
    logic [7:0] shadow_d [4];
    logic seen_q;
    logic seen_d;
    logic hit;
    logic [1:0] idx;
    logic [7:0] exp_rd;
    assign hit = reg_addr_i inside {8'h07, 8'h09, 8'h0b, 8'h0d};
    assign idx = 2'((reg_addr_i - 8'h07) >> 1);
    assign exp_rd = hit ? shadow_q[idx] : 8'h00;
    // Next shadow bytes and touch history
    always_comb
    begin
        shadow_d = shadow_q;
        seen_d = seen_q | (|group_touch_i);
        if (reg_wr_i && hit)
        begin
            shadow_d[idx] = reg_wdata_i;
        end
    end
    // Registers only; reset mirrors the block
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            shadow_q <= '{default: 8'h00};
            seen_q <= 1'b0;
        end
        else
        begin
            shadow_q <= shadow_d;
            seen_q <= seen_d;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_all_clear: assert property (disable iff (1'b0) sys_rst_i |=> general_output_n_o == 10'h3ff)
        else $error("reset state wrong");
    a_read_mapped: assert property (reg_rd_i && hit |=> reg_rdata_o == $past(exp_rd))
        else $error("read data wrong");
    a_read_unmapped: assert property (reg_rd_i && !hit |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    a_write_then_read: assert property (reg_wr_i && hit && !reg_rd_i ##1 reg_rd_i && !reg_wr_i
        && $stable(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("readback wrong");
    a_group1_same: assert property (&general_output_n_o[3:1] || !(|general_output_n_o[3:1]))
        else $error("group one split");
    a_group2_same: assert property (&general_output_n_o[6:4] || !(|general_output_n_o[6:4]))
        else $error("group two split");
    a_group3_same: assert property (&general_output_n_o[9:7] || !(|general_output_n_o[9:7]))
        else $error("group three split");
    a_untouched_dark: assert property (!seen_q && !(|group_touch_i) |-> general_output_n_o == 10'h3ff)
        else $error("lit before touch");
endmodule
bind led_fade_low_phase_config fade_cfg_props u_props (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .group_touch_i(group_touch_i), .general_output_n_o(general_output_n_o));

// file: tb/led_bank_model.sv
// Purpose: Ten LEDs on active-low drive
// Assumes: A low drive lights the LED
// Notes: Lit cycles counted per LED, cleared by clr_i
`timescale 1ns/1ps
module led_bank_model
(
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [9:0] drive_n_i,
    output logic [9:0][15:0] lit_cnt_o
);
    // Duty seen by eye is the lit share of a window
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 10; i++)
        begin
            lit_cnt_o[i] <= clr_i ? 16'h0000 : lit_cnt_o[i] + 16'(!drive_n_i[i]);
        end
    end
endmodule

// file: tb/test_led_fade_low_phase_config.sv
// Purpose: Self-checking bench for the low-phase fade block
// Assumes: Tick of 2 clocks, so 1 percent per 2P clocks
// Notes: Brightness judged by lit counts of the LED model
`timescale 1ns/1ps
module test_led_fade_low_phase_config
    import led_fade_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    period_t [3:0] global_fade_period_i = {4{8'h01}};
    logic [3:0] group_touch_i = 4'h0;
    logic [9:0] general_output_n_o;
    logic clr = 1'b1;
    logic [9:0][15:0] lit_cnt;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] ofs [4] = '{8'h07, 8'h09, 8'h0b, 8'h0d};
    int pct [8] = '{0, 10, 20, 30, 40, 60, 80, 100};
    // Small tick keeps the run short
    led_fade_low_phase_config #(.PCT_TICK_CYCLES(2)) dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .global_fade_period_i(global_fade_period_i), .high_cfg_i('0),
        .group_touch_i(group_touch_i), .general_output_n_o(general_output_n_o));
    led_bank_model leds (.clk_i(core_clk_i), .clr_i(clr), .drive_n_i(general_output_n_o), .lit_cnt_o(lit_cnt));
    initial
    begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
    endtask
    // Data stands until the next read, so one spare cycle is safe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        step(1);
        reg_rd_i = 1'b0;
        step(1);
        check("reg_rdata", 16'(reg_rdata_o), 16'(exp));
    endtask
    // Touch a group, skip ahead, then count lit cycles over a window
    task automatic effect(input int g, input logic [7:0] cfg, input int skip, input int win);
        wr(ofs[g], cfg);
        group_touch_i[g] = 1'b1;
        step(skip);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(win);
    endtask
    // Long rest so a cut-short effect settles back to idle
    task automatic release_all();
        group_touch_i = 4'h0;
        step(1500);
    endtask
    task automatic t_regs();
        for (int g = 0; g < 4; g++)
        begin
            rd(ofs[g], 8'h00);
            wr(ofs[g], 8'ha5 + 8'(g));
            rd(ofs[g], 8'ha5 + 8'(g));
        end
        rd(8'h08, 8'h00);
    endtask
    task automatic t_low_target();
        for (int c = 0; c < 8; c++)
        begin
            effect(c % 4, {2'b00, 3'(c), 3'b000}, 1000, 100);
            for (int i = 0; i < 10; i++)
            begin
                check("lit_window", lit_cnt[i], ((i + 2) / 3 == c % 4) ? 16'(pct[c]) : 16'h0000);
            end
            release_all();
        end
    endtask
    // Lit total grows 100 per ramp period step and 200 per hold step
    task automatic t_timing();
        int e;
        global_fade_period_i = {8'h04, 8'h03, 8'h02, 8'h01};
        for (int k = 0; k < 5; k++)
        begin
            effect(0, {2'(k % 4), 4'h0, k == 4, 1'b0}, 0, 2500);
            e = 100 + 200 * ((k == 4) + 1) + 100 * (k % 4 + 1);
            check("lit_total", 16'(int'(lit_cnt[0]) + 40 > e && int'(lit_cnt[0]) < e + 40), 16'h0001);
            release_all();
        end
    endtask
    task automatic t_repeat();
        global_fade_period_i = {8'h01, 8'h01, 8'h03, 8'h01};
        for (int k = 0; k < 3; k++)
        begin
            effect(0, {5'h00, k < 2, 1'b0, k == 1}, 900, 100);
            check("relit", 16'(lit_cnt[0] != 0), 16'(k == 0));
            release_all();
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && n_checks > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial
    begin
        #8000000;
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        step(6);
        sys_rst_i = 1'b0;
        t_regs();
        t_low_target();
        t_timing();
        t_repeat();
        tally_and_finish();
    end
endmodule
